// ===== hspac_top.sv
/*
  Hall signal path: per-axis trim, axis pair select, angle and squared
  radius, temperature result and sample trigger, with AXI4-Lite
  registers. Assumes a front end that returns one filtered sample per
  fe_start_o request and signals it with fe_done_i.
*/
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "hspac_defs.svh"

// What this block does
// - each axis result offered as short 8-bit and long 15-bit form
// - correct axis: add offset, gain and sign, offset tempco, gain tempco
// - uncorrected filter output of each axis readable by host
// - gain trim and both tempco coefficients per axis are host writable
// - angle from any two axes; pair from stored or volatile setting
// - pair select decode, codes 6 and 7 act as X cosine Y sine
// - sine and cosine values stored in short and long result registers
// - angle is full-circle arctangent of sine over cosine
// - invert setting gives 360 minus angle, otherwise angle unchanged
// - volatile invert control overrides stored one without changing it
// - final angle written to short and long angle registers
// - squared radius computed with each angle, short and long forms
// - 12-bit temperature code, degrees equal code over 8.052 plus 25
// - multifunction pin is interrupt output or sample input by mode
// - sample modes wait in standby until pin or start bit triggers
// - trigger is pin edge to chosen level or host start bit
// - after trigger acquire, update outputs, then assert ready
// - after results post, return to standby for next trigger
// - triggers during an acquisition are ignored
module hspac_top
  import hspac_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             fe_start_o,
  input  wire logic        fe_done_i,
  input  wire hspac_axis_t fe_raw_x_i,
  input  wire hspac_axis_t fe_raw_y_i,
  input  wire hspac_axis_t fe_raw_z_i,
  input  wire logic [11:0] fe_temp_i,
  input  wire logic [2:0]  angle_pair_select_stored_i,
  input  wire logic        angle_invert_stored_i,
  input  wire logic        sample_pin_i,
  output logic             sample_pin_o,
  output logic             sample_pin_oe_o
);

  // bus group
  logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [`HSPAC_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [15:0] trim_q [0:11];
  logic [15:0] trim_d [0:11];
  logic        start_q, start_d;
  logic        wr_fire, ready_clr;
  logic [31:0] merged;

  // sequencer group
  hspac_state_t state_q, state_d;
  hspac_axis_t  raw_q [0:2];
  hspac_axis_t  raw_d [0:2];
  hspac_axis_t  corr_q [0:2];
  hspac_axis_t  corr_d [0:2];
  hspac_axis_t  corr_w [0:2];
  logic signed [11:0] temp_q, temp_d;
  hspac_axis_t  sin_q, sin_d, cos_q, cos_d;
  logic [14:0]  ang_q, ang_d, mag_q, mag_d;
  logic         ready_q, ready_d, act_prev_q, act_prev_d;

  logic [2:0]   mode, psel;
  logic         invert, pin_act, pin_edge, trig, sample_mode, run_mode;
  logic [29:0]  sum_sq;
  hspac_cordic_if cif ();

  function automatic logic [31:0] pack_res(input logic [14:0] v);
    pack_res = {8'h00, v[14:7], 1'b0, v};
  endfunction : pack_res

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = strb[b] ? dat[b*8 +: 8] : old[b*8 +: 8];
    end
    strb_merge = old;
  endfunction : strb_merge

  assign mode   = ctrl_q[`HSPAC_CTRL_MODE +: 3];
  // volatile copies win only when selected, the stored inputs stay as they are
  assign psel   = ctrl_q[`HSPAC_CTRL_USEVOL] ? ctrl_q[`HSPAC_CTRL_PSEL +: 3]
                                             : angle_pair_select_stored_i;
  assign invert = ctrl_q[`HSPAC_CTRL_USEVOL] ? ctrl_q[`HSPAC_CTRL_INV]
                                             : angle_invert_stored_i;

  // per-axis trim, all arithmetic signed and wide enough not to wrap
  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [47:0] sa, sb, sc, sf, so;
    always_comb begin
      sa = 48'(raw_q[a]) + 48'($signed(trim_q[a*4]));
      sb = (sa * 48'($signed({1'b0, trim_q[a*4+1]}))) >>> `HSPAC_GAIN_SHIFT;
      if (ctrl_q[`HSPAC_CTRL_SIGN + a]) begin
        sb = -sb;
      end
      sc = sb + ((48'($signed(trim_q[a*4+2])) * 48'(temp_q)) >>> `HSPAC_OTC_SHIFT);
      // unity term must stay signed or the whole sum goes unsigned
      sf = $signed(48'(`HSPAC_GAIN_ONE))
         + ((48'($signed(trim_q[a*4+3])) * 48'(temp_q)) >>> `HSPAC_GTC_SHIFT);
      so = (sc * sf) >>> `HSPAC_GAIN_SHIFT;
      // saturate instead of wrapping so a strong field never flips sign
      if (so > 48'sh3FFF) begin
        corr_w[a] = 15'sh3FFF;
      end else if (so < -48'sh4000) begin
        corr_w[a] = 15'sh4000;
      end else begin
        corr_w[a] = so[14:0];
      end
    end
  end

  always_comb begin
    case (psel)
      3'h1: begin cif.cos_v = corr_q[0]; cif.sin_v = corr_q[2]; end
      3'h2: begin cif.cos_v = corr_q[1]; cif.sin_v = corr_q[2]; end
      3'h3: begin cif.cos_v = corr_q[1]; cif.sin_v = corr_q[0]; end
      3'h4: begin cif.cos_v = corr_q[2]; cif.sin_v = corr_q[0]; end
      3'h5: begin cif.cos_v = corr_q[2]; cif.sin_v = corr_q[1]; end
      default: begin cif.cos_v = corr_q[0]; cif.sin_v = corr_q[1]; end
    endcase
  end

  hspac_cordic u_cordic (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .cif       (cif)
  );

  assign sum_sq = 30'(cif.cos_v * cif.cos_v) + 30'(cif.sin_v * cif.sin_v);

  // pin direction follows mode; threshold compare logic sits outside
  assign sample_mode     = (mode == MODE_SAMPLE) || (mode == MODE_SLEEP_WAKE);
  assign run_mode        = !sample_mode && (mode != MODE_SLEEP);
  assign sample_pin_oe_o = (mode == MODE_ACTIVE_INT) || (mode == MODE_LPDC_INT);
  assign sample_pin_o    = 1'b0;
  assign pin_act  = ctrl_q[`HSPAC_CTRL_POL] ? sample_pin_i : !sample_pin_i;
  assign pin_edge = sample_mode && pin_act && !act_prev_q;
  assign trig     = pin_edge || start_q;
  assign fe_start_o = (state_q == ST_ACQ);
  assign cif.start  = (state_q == ST_LOAD);

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  assign wr_fire   = aw_held_q && w_held_q && !bvalid_q;
  assign ready_clr = wr_fire && (awaddr_q == `HSPAC_A_CMD) && wstrb_q[0]
                   && wdata_q[`HSPAC_CMD_READY];

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    ctrl_d    = ctrl_q;
    trim_d    = trim_q;
    start_d   = 1'b0;
    merged    = 32'h0000_0000;
    if (s_axi_awvalid && !aw_held_q) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = 2'h0;
      if (awaddr_q == `HSPAC_A_CTRL) begin
        merged = strb_merge(32'(ctrl_q), wdata_q, wstrb_q);
        ctrl_d = merged[`HSPAC_CTRL_W-1:0];
      end else if (awaddr_q == `HSPAC_A_CMD) begin
        // start is ignored while a conversion runs, see sequencer
        start_d = wstrb_q[0] && wdata_q[`HSPAC_CMD_START];
      end else if (awaddr_q >= `HSPAC_A_TRIM && awaddr_q <= `HSPAC_A_TRIM_END
                   && awaddr_q[1:0] == 2'h0) begin
        merged = strb_merge(32'(trim_q[4'(awaddr_q[7:2] - 6'h10)]),
                            wdata_q, wstrb_q);
        trim_d[4'(awaddr_q[7:2] - 6'h10)] = merged[15:0];
      end else if (!(awaddr_q >= `HSPAC_A_RAW_X && awaddr_q <= `HSPAC_A_TEMP
                     && awaddr_q[1:0] == 2'h0)) begin
        bresp_d = 2'h2;
      end
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = 2'h0;
      rdata_d  = 32'h0000_0000;
      case (s_axi_araddr)
        `HSPAC_A_CTRL:   rdata_d = 32'(ctrl_q);
        `HSPAC_A_CMD:    rdata_d = {29'h0, (state_q != ST_IDLE), ready_q, 1'b0};
        8'h08:           rdata_d = pack_res(raw_q[0]);
        8'h0C:           rdata_d = pack_res(raw_q[1]);
        8'h10:           rdata_d = pack_res(raw_q[2]);
        8'h14:           rdata_d = pack_res(corr_q[0]);
        8'h18:           rdata_d = pack_res(corr_q[1]);
        8'h1C:           rdata_d = pack_res(corr_q[2]);
        `HSPAC_A_SINE:   rdata_d = pack_res(sin_q);
        `HSPAC_A_COSINE: rdata_d = pack_res(cos_q);
        `HSPAC_A_ANGLE:  rdata_d = pack_res(ang_q);
        `HSPAC_A_MAGSQ:  rdata_d = pack_res(mag_q);
        `HSPAC_A_TEMP:   rdata_d = 32'($signed(temp_q));
        default: begin
          if (s_axi_araddr >= `HSPAC_A_TRIM && s_axi_araddr <= `HSPAC_A_TRIM_END
              && s_axi_araddr[1:0] == 2'h0) begin
            rdata_d = 32'(trim_q[4'(s_axi_araddr[7:2] - 6'h10)]);
          end else begin
            rresp_d = 2'h2;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0000_0000;
      ctrl_q    <= `HSPAC_CTRL_RST;
      start_q   <= 1'b0;
      for (int i = 0; i < 12; i++) begin
        trim_q[i] <= (i % 4 == 1) ? `HSPAC_GAIN_ONE : 16'h0000;
      end
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      ctrl_q    <= ctrl_d;
      start_q   <= start_d;
      trim_q    <= trim_d;
    end
  end

  always_comb begin
    state_d    = state_q;
    raw_d      = raw_q;
    corr_d     = corr_q;
    temp_d     = temp_q;
    sin_d      = sin_q;
    cos_d      = cos_q;
    ang_d      = ang_q;
    mag_d      = mag_q;
    act_prev_d = pin_act;
    // a new ready wins over a clear that lands in the same cycle
    ready_d    = ready_clr ? 1'b0 : ready_q;
    case (state_q)
      ST_IDLE: begin
        // with latching on, nothing starts until software clears ready
        if (!(ctrl_q[`HSPAC_CTRL_LATCH] && ready_q)
            && ((sample_mode && trig) || run_mode)) begin
          state_d = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (fe_done_i) begin
          raw_d[0] = fe_raw_x_i;
          raw_d[1] = fe_raw_y_i;
          raw_d[2] = fe_raw_z_i;
          temp_d   = fe_temp_i;
          state_d  = ST_CORR;
        end
      end
      ST_CORR: begin
        corr_d  = corr_w;
        state_d = ST_LOAD;
      end
      ST_LOAD: begin
        sin_d   = cif.sin_v;
        cos_d   = cif.cos_v;
        mag_d   = sum_sq[29:15];
        state_d = ST_CALC;
      end
      ST_CALC: begin
        if (cif.done) begin
          ang_d   = invert ? 15'(15'h0000 - cif.angle) : cif.angle;
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // triggers outside standby fall through unused here
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q    <= ST_IDLE;
      temp_q     <= 12'sh000;
      sin_q      <= 15'sh0000;
      cos_q      <= 15'sh0000;
      ang_q      <= 15'h0000;
      mag_q      <= 15'h0000;
      ready_q    <= 1'b0;
      act_prev_q <= 1'b1;
      for (int i = 0; i < 3; i++) begin
        raw_q[i]  <= 15'sh0000;
        corr_q[i] <= 15'sh0000;
      end
    end else begin
      state_q    <= state_d;
      raw_q      <= raw_d;
      corr_q     <= corr_d;
      temp_q     <= temp_d;
      sin_q      <= sin_d;
      cos_q      <= cos_d;
      ang_q      <= ang_d;
      mag_q      <= mag_d;
      ready_q    <= ready_d;
      act_prev_q <= act_prev_d;
    end
  end

endmodule : hspac_top

// ===== hspac_defs.svh
/*
  Offsets, field positions, reset values and arithmetic scaling for the
  hall signal path and angle block. Assumes byte addresses on an
  AXI4-Lite bus with 32-bit data, one aligned word per register.
*/
`ifndef HSPAC_DEFS_SVH
`define HSPAC_DEFS_SVH

`define HSPAC_A_CTRL      8'h00
`define HSPAC_A_CMD       8'h04
`define HSPAC_A_RAW_X     8'h08
`define HSPAC_A_CORR_X    8'h14
`define HSPAC_A_SINE      8'h20
`define HSPAC_A_COSINE    8'h24
`define HSPAC_A_ANGLE     8'h28
`define HSPAC_A_MAGSQ     8'h2C
`define HSPAC_A_TEMP      8'h30
`define HSPAC_A_TRIM      8'h40
`define HSPAC_A_TRIM_END  8'h6C

`define HSPAC_CTRL_MODE   0
`define HSPAC_CTRL_PSEL   3
`define HSPAC_CTRL_INV    6
`define HSPAC_CTRL_POL    7
`define HSPAC_CTRL_LATCH  8
`define HSPAC_CTRL_USEVOL 9
`define HSPAC_CTRL_SIGN   10
`define HSPAC_CTRL_W      13
`define HSPAC_CTRL_RST    13'h0080

`define HSPAC_CMD_START   0
`define HSPAC_CMD_READY   1
`define HSPAC_CMD_BUSY    2

`define HSPAC_GAIN_ONE    16'h4000
`define HSPAC_GAIN_SHIFT  14
`define HSPAC_OTC_SHIFT   8
`define HSPAC_GTC_SHIFT   16
`define HSPAC_CORDIC_ITER 15

`endif

// ===== hspac_pkg.sv
/*
  Types shared by the hall signal path modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hspac_pkg;

  typedef logic signed [14:0] hspac_axis_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ACQ  = 5'b00010,
    ST_CORR = 5'b00100,
    ST_LOAD = 5'b01000,
    ST_CALC = 5'b10000
  } hspac_state_t;

  typedef enum logic [2:0] {
    MODE_ACTIVE     = 3'h0,
    MODE_ACTIVE_INT = 3'h1,
    MODE_SAMPLE     = 3'h2,
    MODE_SLEEP      = 3'h3,
    MODE_SLEEP_WAKE = 3'h4,
    MODE_LPDC_INT   = 3'h5,
    MODE_LPDC       = 3'h6,
    MODE_ACTIVE_ALT = 3'h7
  } hspac_mode_t;

endpackage : hspac_pkg

// ===== hspac_cordic_if.sv
/*
  Request and answer between the sequencer and the arctangent engine.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface hspac_cordic_if;
  import hspac_pkg::*;
  logic        start;
  hspac_axis_t cos_v;
  hspac_axis_t sin_v;
  logic        done;
  logic [14:0] angle;
  modport seq (output start, output cos_v, output sin_v, input done, input angle);
  modport eng (input start, input cos_v, input sin_v, output done, output angle);
endinterface : hspac_cordic_if

// ===== hspac_cordic.sv
/*
  Iterative vectoring arctangent over the full circle; 2^15 codes per
  turn. Assumes start is one pulse and is not repeated before done.
*/
`timescale 1ns/10ps
`include "hspac_defs.svh"
module hspac_cordic
  import hspac_pkg::*;
(
  input  wire logic   ref_clk_i,
  input  wire logic   rst_i,
  hspac_cordic_if.eng cif
);

  logic signed [17:0] x_q, x_d, y_q, y_d;
  logic        [15:0] z_q, z_d;
  logic        [3:0]  it_q, it_d;
  logic               busy_q, busy_d, done_q, done_d;
  logic        [14:0] ang_q, ang_d;

  function automatic logic [15:0] atan_lut(input logic [3:0] i);
    case (i)
      4'h0: atan_lut = 16'h2000;
      4'h1: atan_lut = 16'h12E4;
      4'h2: atan_lut = 16'h09FB;
      4'h3: atan_lut = 16'h0511;
      4'h4: atan_lut = 16'h028B;
      4'h5: atan_lut = 16'h0146;
      4'h6: atan_lut = 16'h00A3;
      4'h7: atan_lut = 16'h0051;
      4'h8: atan_lut = 16'h0029;
      4'h9: atan_lut = 16'h0014;
      4'hA: atan_lut = 16'h000A;
      4'hB: atan_lut = 16'h0005;
      4'hC: atan_lut = 16'h0003;
      4'hD: atan_lut = 16'h0001;
      default: atan_lut = 16'h0001;
    endcase
  endfunction : atan_lut

  always_comb begin
    x_d    = x_q;
    y_d    = y_q;
    z_d    = z_q;
    it_d   = it_q;
    busy_d = busy_q;
    done_d = 1'b0;
    ang_d  = ang_q;
    if (cif.start) begin
      // left half plane is folded by 180 degrees so the loop converges
      if (cif.cos_v < 0) begin
        x_d = -18'(cif.cos_v);
        y_d = -18'(cif.sin_v);
        z_d = 16'h8000;
      end else begin
        x_d = 18'(cif.cos_v);
        y_d = 18'(cif.sin_v);
        z_d = 16'h0000;
      end
      it_d   = 4'h0;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (y_q >= 0) begin
        x_d = x_q + (y_q >>> it_q);
        y_d = y_q - (x_q >>> it_q);
        z_d = z_q + atan_lut(it_q);
      end else begin
        x_d = x_q - (y_q >>> it_q);
        y_d = y_q + (x_q >>> it_q);
        z_d = z_q - atan_lut(it_q);
      end
      it_d = it_q + 4'h1;
      if (it_q == 4'(`HSPAC_CORDIC_ITER - 1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        ang_d  = z_d[15:1];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      x_q    <= 18'sh00000;
      y_q    <= 18'sh00000;
      z_q    <= 16'h0000;
      it_q   <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ang_q  <= 15'h0000;
    end else begin
      x_q    <= x_d;
      y_q    <= y_d;
      z_q    <= z_d;
      it_q   <= it_d;
      busy_q <= busy_d;
      done_q <= done_d;
      ang_q  <= ang_d;
    end
  end

  assign cif.done  = done_q;
  assign cif.angle = ang_q;

endmodule : hspac_cordic

// ===== hspac_top_chk.sv
/* timing checks on the ports of hspac_top.
   assumes a bind from the bench top, one clock, sync reset */
`timescale 1ns/10ps
module hspac_top_chk (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        fe_start_o,
  input wire logic        fe_done_i,
  input wire logic        sample_pin_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_rd_one_cycle: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read answer not one cycle after request");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  chk_resp_legal: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
    else $error("read response code not okay or slave error");
  chk_acq_wait: assert property (fe_start_o && !fe_done_i |=> fe_start_o)
    else $error("sample request withdrawn before answer");
  chk_one_per_trig: assert property (fe_start_o && fe_done_i |=> !fe_start_o [*8])
    else $error("new sample request while results pending");
  chk_reset_idle: assert property ($fell(rst_i) |-> !fe_start_o)
    else $error("sample request out of reset");
  chk_pin_quiet: assert property (!sample_pin_o)
    else $error("multifunction pin driven high");
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (fe_start_o && fe_done_i);
endmodule : hspac_top_chk

// ===== hspac_fe_model.sv
/* front end stand-in: answers a sample request after lat_i cycles.
   assumes the bench sets the values before the answer cycle */
`timescale 1ns/10ps
module hspac_fe_model
  import hspac_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        fe_start_i,
  input  wire logic [3:0]  lat_i,
  input  wire hspac_axis_t v_i [3],
  input  wire logic [11:0] t_i,
  output logic             fe_done_o,
  output hspac_axis_t      x_o,
  output hspac_axis_t      y_o,
  output hspac_axis_t      z_o,
  output logic [11:0]      t_o
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  always_comb cnt_d = (fe_start_i && !fe_done_o) ? cnt_q + 4'h1 : 4'h0;
  always_ff @(posedge ref_clk_i) cnt_q <= rst_i ? 4'h0 : cnt_d;
  assign fe_done_o = fe_start_i && (cnt_q == lat_i);
  // off the answer cycle values are inverted, so stale captures show
  assign x_o = fe_done_o ? v_i[0] : ~v_i[0];
  assign y_o = fe_done_o ? v_i[1] : ~v_i[1];
  assign z_o = fe_done_o ? v_i[2] : ~v_i[2];
  assign t_o = fe_done_o ? t_i : ~t_i;
endmodule : hspac_fe_model

// ===== hspac_top_tb.sv
/* bench for hspac_top: bus master, front end stand-in, checks.
   assumes design, checker and front end model compiled first */
`timescale 1ns/10ps
`include "hspac_defs.svh"
module hspac_top_tb;
  import hspac_pkg::*;
  localparam int CA[8] = '{0, 0, 1, 1, 2, 2, 0, 0};
  localparam int SA[8] = '{1, 2, 2, 0, 0, 1, 1, 1};
  localparam logic [31:0] M = 32'h00FF7FFF;
  logic        clk = 0, rst = 1, aw_v = 0, aw_r, w_v = 0, w_r, b_v, b_y = 0;
  logic        ar_v = 0, ar_r, r_v, r_y = 0, fs, fd, pin = 0, po, poe, sinv = 0, pol = 1;
  logic [7:0]  aa = 0, ra = 0;
  logic [31:0] wd = 0, rdat;
  logic [1:0]  brs, rrs;
  logic [2:0]  sps = 0;
  logic [3:0]  lat = 0;
  logic [11:0] vt = 0, mt;
  hspac_axis_t v[3] = '{default: 0};
  hspac_axis_t mx, my, mz;
  int          err_count = 0, total_checks = 0, cyc = 0, acq_n = 0;
  always #12.5 clk = ~clk;
  hspac_top hspac_top_inst (.ref_clk_i(clk), .rst_i(rst), .s_axi_awaddr(aa),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(brs), .s_axi_bvalid(b_v),
    .s_axi_bready(b_y), .s_axi_araddr(ra), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(rdat), .s_axi_rresp(rrs), .s_axi_rvalid(r_v), .s_axi_rready(r_y),
    .fe_start_o(fs), .fe_done_i(fd), .fe_raw_x_i(mx), .fe_raw_y_i(my), .fe_raw_z_i(mz),
    .fe_temp_i(mt), .angle_pair_select_stored_i(sps), .angle_invert_stored_i(sinv),
    .sample_pin_i(pin), .sample_pin_o(po), .sample_pin_oe_o(poe));
  hspac_fe_model hspac_fe_model_inst (.ref_clk_i(clk), .rst_i(rst), .fe_start_i(fs),
    .lat_i(lat), .v_i(v), .t_i(vt), .fe_done_o(fd), .x_o(mx), .y_o(my), .z_o(mz), .t_o(mt));
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fs && fd) acq_n <= acq_n + 1;
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [31:0] lf(int x);
    return {8'h00, x[14:7], 1'b0, x[14:0]};
  endfunction : lf
  function automatic logic ang_ok(int s, int co, logic inv, logic [14:0] g);
    int e;
    int dd;
    e = int'($atan2(real'(s), real'(co)) * 16384.0 / 3.14159265);
    if (inv) e = -e;
    dd = (int'(g) - e) & 32'h7FFF;
    return dd <= 8 || dd >= 32760;
  endfunction : ang_ok
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ha, hw, hb;
    hb = 0;
    @(posedge clk);
    aa <= a;
    wd <= d;
    aw_v <= 1;
    w_v <= 1;
    b_y <= 1;
    while (!hb) begin
      @(negedge clk);
      ha = aw_v && aw_r;
      hw = w_v && w_r;
      hb = b_v && b_y;
      rs = brs;
      @(posedge clk);
      if (ha) aw_v <= 0;
      if (hw) w_v <= 0;
    end
    b_y <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ha, hr;
    hr = 0;
    @(posedge clk);
    ra <= a;
    ar_v <= 1;
    r_y <= 1;
    while (!hr) begin
      @(negedge clk);
      ha = ar_v && ar_r;
      hr = r_v;
      d = rdat;
      rs = rrs;
      @(posedge clk);
      if (ha) ar_v <= 0;
    end
    r_y <= 0;
  endtask : rd
  // the wait lets any acquisition set off by the change run out
  task automatic setup(input logic [31:0] c);
    logic [1:0] rs;
    wr(`HSPAC_A_CTRL, c, rs);
    repeat (40) @(posedge clk);
    wr(`HSPAC_A_CMD, 32'h2, rs);
  endtask : setup
  task automatic acq(input logic by_pin);
    logic [31:0] d;
    logic [1:0]  rs;
    int          n, k;
    n = acq_n;
    for (k = 0; k < 3; k++) v[k] <= 15'($urandom_range(30000) - 15000);
    vt <= 12'($urandom);
    lat <= 4'($urandom_range(6));
    if (!by_pin) wr(`HSPAC_A_CMD, 32'h1, rs);
    @(posedge clk);
    pin <= pol; // trigger by pin, or a late edge while busy
    repeat (4) @(posedge clk);
    pin <= !pol;
    k = 0;
    do begin
      rd(`HSPAC_A_CMD, d, rs);
      k++;
    end while (d[1] !== 1'b1 && k < 60);
    chk(d & 32'h6, 32'h2);
    chk(acq_n - n, 1);
  endtask : acq
  initial begin
    logic [31:0] d, c;
    logic [1:0]  rs;
    int          n, cv[3], s, co, ep;
    logic        uv, ei;
    void'($urandom(45775));
    repeat (20) @(posedge clk);
    rst <= 0;
    rd(`HSPAC_A_CTRL, d, rs);
    chk(d & 32'h1FFF, 32'h80);
    rd(8'h44, d, rs);
    chk(d & 32'hFFFF, 32'h4000);
    rd(8'h38, d, rs);
    chk({rs, d[29:0]}, {2'h2, 30'h0});
    wr(8'h3C, 32'h1, rs);
    chk(rs, 2'h2);
    setup(32'h81);
    chk(poe, 1'b1);
    setup(32'h282);
    chk(poe, 1'b0);
    n = acq_n;
    repeat (60) @(posedge clk);
    chk(acq_n, n);
    for (int i = 0; i < 10; i++) begin
      uv = (i < 8);
      c = $urandom;
      pol = uv;
      pin <= !uv;
      sps <= 3'((i * 3 + 1) % 8);
      sinv <= c[20];
      ep = uv ? i % 8 : (i * 3 + 1) % 8;
      ei = uv ? c[6] : c[20];
      setup({19'h0, c[12:10], uv, 1'b0, uv, c[6], 3'(i), 3'h2});
      acq(i[0]);
      for (int k = 0; k < 3; k++) begin
        cv[k] = c[10 + k] ? -int'(v[k]) : int'(v[k]);
        rd(8'(`HSPAC_A_RAW_X + 4 * k), d, rs);
        chk(d & 32'h7FFF, lf(v[k]) & 32'h7FFF);
        rd(8'(`HSPAC_A_CORR_X + 4 * k), d, rs);
        chk(d & M, lf(cv[k]));
      end
      s = cv[SA[ep]];
      co = cv[CA[ep]];
      rd(`HSPAC_A_SINE, d, rs);
      chk(d & M, lf(s));
      rd(`HSPAC_A_COSINE, d, rs);
      chk(d & M, lf(co));
      rd(`HSPAC_A_MAGSQ, d, rs);
      chk(d & M, lf((co * co + s * s) >>> 15));
      rd(`HSPAC_A_ANGLE, d, rs);
      chk(ang_ok(s, co, ei, d[14:0]) && d[23:16] === d[14:7], 1'b1);
      rd(`HSPAC_A_TEMP, d, rs);
      chk(d & 32'hFFF, 32'(vt));
      wr(`HSPAC_A_CMD, 32'h2, rs);
      rd(`HSPAC_A_CMD, d, rs);
      chk(d & 32'h7, 32'h0);
    end
    pol = 1;
    pin <= 0;
    setup(32'h182);
    acq(0);
    n = acq_n;
    wr(`HSPAC_A_CMD, 32'h1, rs);
    repeat (40) @(posedge clk);
    chk(acq_n, n);
    conclude();
  end
endmodule : hspac_top_tb
bind hspac_top hspac_top_chk hspac_top_chk_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .fe_start_o(fe_start_o), .fe_done_i(fe_done_i), .sample_pin_o(sample_pin_o));
